// file: acr_pkg.sv
package acr_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_CON_MAIN = 8'h00_A3;
   localparam logic [7:0] IDX_CON_GAIN = 8'h00_A4;
   localparam logic [7:0] IDX_CHAN = 8'h00_A5;
   localparam logic [7:0] IDX_PINS = 8'h00_A6;
   localparam logic [7:0] IDX_OVERRIDE = 8'h00_A7;
   localparam logic [7:0] IDX_TRIM = 8'h00_A8;
   // field positions
   localparam int EN_BIT = 7;
   localparam int CP_BIT = 5;
   localparam int UG_BIT = 3;
   localparam int SOC_LSB = 0;
   localparam int GAIN_LADDER_SELECT_LSB = 4;
   localparam int LADDER_BIT = 3;
   localparam int NSS_LSB = 0;
   localparam int PCH_LSB = 0;
   localparam int PSS_LSB = 0;
   localparam int OVERRIDE_ENABLE_BIT = 7;
   localparam int HWCH_LSB = 4;
   localparam int ORPOL_BIT = 3;
   localparam int HWCL_LSB = 0;
   // implemented bits and values after reset
   localparam logic [7:0] MASK_CON_MAIN = 8'h00_AB;
   localparam logic [7:0] MASK_CON_GAIN = 8'h00_7F;
   localparam logic [7:0] MASK_CHAN = 8'h00_07;
   localparam logic [7:0] MASK_PINS = 8'h00_03;
   localparam logic [7:0] MASK_FULL = 8'h00_FF;
   localparam logic [7:0] RST_REG = 8'h00_00;
   // mode and selection codes
   localparam logic [1:0] SOC_LOW = 2'h0_1;
   localparam logic [1:0] SOC_HIGH = 2'h0_2;
   localparam logic [2:0] HW_UNITY = 3'h0_4;
   localparam logic [2:0] HW_RAIL = 3'h0_7;
   localparam logic [2:0] NSS_LAST_PIN = 3'h0_3;
   localparam logic [2:0] NSS_VSS = 3'h0_7;
   localparam logic [2:0] PCH_PIN = 3'h0_2;
   localparam logic [2:0] PCH_LAST = 3'h0_5;
   localparam logic [4:0] LADDER_TOTAL = 5'h1_0;
   localparam int ADC_CH_W = 6;
   localparam logic [5:0] NI_PIN_COUNT = 6'h0_4;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0_0;
   localparam logic [1:0] RESP_DECERR = 2'h0_3;

   typedef enum logic [0:0] {
      ACR_W_TAKE = 1'b0,
      ACR_W_RESP = 1'b1
   } acr_wr_state_t;

   typedef enum logic [0:0] {
      ACR_R_IDLE = 1'b0,
      ACR_R_DATA = 1'b1
   } acr_rd_state_t;

   // decoded analog controls
   typedef struct packed {
      logic power;
      logic cp;
      logic unity;
      logic drv_lo;
      logic drv_hi;
      logic ladder;
      logic [4:0] r1;
      logic [4:0] r2;
      logic [3:0] inv_pin;
      logic inv_vss;
      logic inv_release;
      logic [5:0] ni_chan;
      logic [3:0] ni_pin;
      logic adc_amp;
      logic pin_port_off;
      logic pin_drive;
   } acr_route_t;
endpackage

// file: acr_ctl_if.sv
`timescale 1ns/100ps
interface acr_ctl_if;
   import acr_pkg::*;
   logic [7:0] con_main;
   logic [7:0] con_gain;
   logic [7:0] chan;
   logic [7:0] pins;
   logic [7:0] ovr;
   logic ovr_src;
   logic [ADC_CH_W-1:0] adc_ch;
   acr_route_t dec;
   modport regs (output con_main, con_gain, chan, pins, ovr, ovr_src,
                 adc_ch, input dec);
   modport route (input con_main, con_gain, chan, pins, ovr, ovr_src,
                  adc_ch, output dec);
endinterface

// file: acr_route.sv
`timescale 1ns/100ps
module acr_route
   import acr_pkg::*;
#(
   parameter logic [ADC_CH_W-1:0] AMP_PIN_CH_BASE = 6'h0_0
) (
   // settings in, decoded controls out
   acr_ctl_if.route c
);
   // ladder split: upper part for each gain code
   function automatic logic [4:0] ladder_r1(input logic [2:0] g);
      case (g)
         3'h0_0: ladder_r1 = 5'h0_F;
         3'h0_1: ladder_r1 = 5'h0_E;
         3'h0_2: ladder_r1 = 5'h0_C;
         3'h0_3: ladder_r1 = 5'h0_8;
         3'h0_4: ladder_r1 = 5'h0_6;
         3'h0_5: ladder_r1 = 5'h0_4;
         3'h0_6: ladder_r1 = 5'h0_2;
         default: ladder_r1 = 5'h0_1;
      endcase
   endfunction

   // mode selection and source routing
   always_comb begin
      logic hw_src;
      logic [2:0] hw;
      logic [2:0] negative_pin_select;
      logic [2:0] noninverting_channel_select;
      logic [ADC_CH_W-1:0] rel;
      acr_route_t d;
      hw_src = c.ovr_src ^ c.ovr[ORPOL_BIT];
      hw = hw_src ? c.ovr[HWCH_LSB +: 3] : c.ovr[HWCL_LSB +: 3];
      negative_pin_select = c.con_gain[NSS_LSB +: 3];
      noninverting_channel_select = c.chan[PCH_LSB +: 3];
      rel = c.adc_ch - AMP_PIN_CH_BASE;
      d = '0;
      d.power = c.con_main[EN_BIT];                          // [RULE_01]
      d.cp = c.con_main[CP_BIT];                             // [RULE_02]
      if (c.ovr[OVERRIDE_ENABLE_BIT]) begin                             // [RULE_13]
         d.unity = (hw == HW_UNITY);
         d.drv_hi = (hw == HW_RAIL) && hw_src;
         d.drv_lo = (hw == HW_RAIL) && !hw_src;
      end else begin
         d.unity = c.con_main[UG_BIT];                       // [RULE_03]
         d.drv_lo = (c.con_main[SOC_LSB +: 2] == SOC_LOW);   // [RULE_04]
         d.drv_hi = (c.con_main[SOC_LSB +: 2] == SOC_HIGH);  // [RULE_04]
      end
      d.drv_lo = d.drv_lo && d.power;
      d.drv_hi = d.drv_hi && d.power;
      d.ladder = c.con_gain[LADDER_BIT];                     // [RULE_06]
      if (d.ladder) begin
         d.r1 = ladder_r1(c.con_gain[GAIN_LADDER_SELECT_LSB +: 3]);        // [RULE_05]
         d.r2 = LADDER_TOTAL - d.r1;                         // [RULE_05]
      end
      d.inv_release = d.unity;                               // [RULE_03]
      if (!d.unity && negative_pin_select <= NSS_LAST_PIN) begin             // [RULE_14]
         d.inv_pin = 4'(4'h0_1 << negative_pin_select[1:0]);
      end
      d.inv_vss = !d.unity && (negative_pin_select == NSS_VSS);              // [RULE_14]
      if (noninverting_channel_select <= PCH_LAST) begin                             // [RULE_15]
         d.ni_chan = 6'(6'h0_1 << noninverting_channel_select);
      end
      if (noninverting_channel_select == PCH_PIN) begin
         d.ni_pin = 4'(4'h0_1 << c.pins[PSS_LSB +: 2]);
      end
      d.adc_amp = (c.adc_ch >= AMP_PIN_CH_BASE)              // [RULE_11]
                  && (rel < NI_PIN_COUNT);
      d.pin_port_off = d.power || d.adc_amp;                 // [RULE_12]
      d.pin_drive = d.power || d.adc_amp;                    // [RULE_12]
      c.dec = d;
   end
endmodule

// file: acr_regs.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01: enable bit powers amplifier, clear shuts down
// RULE_02: charge pump bit switches pump on or off
// RULE_03: unity bit feeds output back, frees pins
// RULE_04: output field: basic, low rail, high rail
// RULE_05: gain field splits ladder, parts sum sixteen
// RULE_06: ladder bit attaches or detaches the ladder
// RULE_07: software adds external feedback without ladder
// RULE_08: trim loads factory value on every reset
// RULE_09: software recalibrates trim using the converter
// RULE_10: external reference needs positive pin select
// RULE_11: converter picks amp pin, gets amp output
// RULE_12: routed output pin stays off general use
// RULE_13: override enable hands mode to hardware fields
// RULE_14: negative select: pins zero-three, low supply
// RULE_15: noninverting select decodes six internal sources
// RULE_16: unused control bits ignore writes, read zero
module acr_regs
   import acr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter logic [ADC_CH_W-1:0] AMP_PIN_CH_BASE = 6'h0_0
) (
   // clock, reset and enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   // axi write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // system inputs on the same clock
   input wire logic [7:0] factory_trim,
   input wire logic override_source,
   input wire logic [ADC_CH_W-1:0] adc_positive_channel,
   // amplifier power and mode
   output logic amp_enable,
   output logic charge_pump_on,
   output logic unity_feedback,
   output logic drive_low_rail,
   output logic drive_high_rail,
   // resistor ladder
   output logic ladder_enable,
   output logic [4:0] ladder_r1,
   output logic [4:0] ladder_r2,
   // input source selection
   output logic [3:0] inverting_input_pin_sel,
   output logic inverting_to_vss,
   output logic inverting_pins_release,
   output logic [5:0] noninverting_channel_sel,
   output logic [3:0] noninverting_input_pin_sel,
   // trim, converter path and output pin
   output logic [7:0] offset_trim,
   output logic adc_from_amp,
   output logic amp_output_pin_port_off,
   output logic amp_output_pin_drive
);
   // all state of the block
   typedef struct packed {
      logic [7:0] con_main;
      logic [7:0] con_gain;
      logic [7:0] chan;
      logic [7:0] pins;
      logic [7:0] ovr;
      logic [7:0] trim;
      acr_wr_state_t wst;
      logic aw_have;
      logic [7:0] aw_idx;
      logic aw_bad;
      logic w_have;
      logic [7:0] wdata;
      logic wbyte;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      acr_rd_state_t rst;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      acr_route_t outq;
   } acr_state_t;

   acr_state_t s;
   acr_state_t next_s;
   acr_state_t rst_s;
   acr_ctl_if ctl ();

   // the index field must fit below the top address bits
   if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr
      $error("acr_regs: ADDR_W must lie in 11..32");
   end

   // index of a register word, upper address bits give out of range
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[9:2];
   endfunction

   function automatic logic addr_bad(input logic [ADDR_W-1:0] a);
      addr_bad = (a[ADDR_W-1:10] != '0);
   endfunction

   // implemented bits of each register, zero where unmapped
   function automatic logic [7:0] reg_mask(input logic [7:0] idx);
      case (idx)
         IDX_CON_MAIN: reg_mask = MASK_CON_MAIN;
         IDX_CON_GAIN: reg_mask = MASK_CON_GAIN;
         IDX_CHAN: reg_mask = MASK_CHAN;
         IDX_PINS: reg_mask = MASK_PINS;
         IDX_OVERRIDE: reg_mask = MASK_FULL;
         IDX_TRIM: reg_mask = MASK_FULL;
         default: reg_mask = RST_REG;
      endcase
   endfunction

   function automatic logic reg_hit(input logic [7:0] idx);
      case (idx)
         IDX_CON_MAIN,
         IDX_CON_GAIN,
         IDX_CHAN,
         IDX_PINS,
         IDX_OVERRIDE,
         IDX_TRIM: reg_hit = 1'b1;
         default: reg_hit = 1'b0;
      endcase
   endfunction

   // settings towards the decoder
   assign ctl.con_main = s.con_main;
   assign ctl.con_gain = s.con_gain;
   assign ctl.chan = s.chan;
   assign ctl.pins = s.pins;
   assign ctl.ovr = s.ovr;
   assign ctl.ovr_src = override_source;
   assign ctl.adc_ch = adc_positive_channel;

   acr_route #(
      .AMP_PIN_CH_BASE(AMP_PIN_CH_BASE)
   ) u_route (
      .c(ctl.route)
   );

   // value after reset, trim reloads the factory setting
   always_comb begin
      rst_s = '0;
      rst_s.con_main = RST_REG;
      rst_s.con_gain = RST_REG;
      rst_s.chan = RST_REG;
      rst_s.pins = RST_REG;
      rst_s.ovr = RST_REG;
      rst_s.trim = factory_trim;                             // [RULE_08]
      rst_s.wst = ACR_W_TAKE;
      rst_s.rst = ACR_R_IDLE;
   end

   // bus slave and register updates
   always_comb begin
      logic [7:0] wv;
      logic [7:0] ri;
      wv = '0;
      ri = '0;
      next_s = s;
      next_s.outq = ctl.dec;
      // write address and data are taken in either order
      case (s.wst)
         ACR_W_TAKE: begin
            if (s_axi_awvalid && s.awready) begin
               next_s.aw_have = 1'b1;
               next_s.aw_idx = word_idx(s_axi_awaddr);
               next_s.aw_bad = addr_bad(s_axi_awaddr);
            end
            if (s_axi_wvalid && s.wready) begin
               next_s.w_have = 1'b1;
               next_s.wdata = s_axi_wdata[7:0];
               next_s.wbyte = s_axi_wstrb[0];
            end
            if (next_s.aw_have && next_s.w_have) begin
               next_s.wst = ACR_W_RESP;
               next_s.bvalid = 1'b1;
               if (next_s.aw_bad || !reg_hit(next_s.aw_idx)) begin
                  next_s.bresp = RESP_DECERR;
               end else begin
                  next_s.bresp = RESP_OKAY;
               end
               wv = next_s.wdata & reg_mask(next_s.aw_idx); // [RULE_16]
               if (next_s.wbyte && !next_s.aw_bad) begin
                  case (next_s.aw_idx)
                     IDX_CON_MAIN: next_s.con_main = wv;
                     IDX_CON_GAIN: next_s.con_gain = wv;
                     IDX_CHAN: next_s.chan = wv;
                     IDX_PINS: next_s.pins = wv;
                     IDX_OVERRIDE: next_s.ovr = wv;
                     IDX_TRIM: next_s.trim = wv;             // [RULE_08]
                     default: next_s.trim = s.trim;
                  endcase
               end
            end
         end
         ACR_W_RESP: begin
            if (s_axi_bready && s.bvalid) begin
               next_s.bvalid = 1'b0;
               next_s.aw_have = 1'b0;
               next_s.w_have = 1'b0;
               next_s.wst = ACR_W_TAKE;
            end
         end
         default: begin
            next_s.wst = ACR_W_TAKE;
         end
      endcase
      next_s.awready = (next_s.wst == ACR_W_TAKE) && !next_s.aw_have;
      next_s.wready = (next_s.wst == ACR_W_TAKE) && !next_s.w_have;
      // read: one answer per request, data held until taken
      case (s.rst)
         ACR_R_IDLE: begin
            if (s_axi_arvalid && s.arready) begin
               ri = word_idx(s_axi_araddr);
               next_s.rst = ACR_R_DATA;
               next_s.rvalid = 1'b1;
               if (addr_bad(s_axi_araddr) || !reg_hit(ri)) begin
                  next_s.rresp = RESP_DECERR;
                  next_s.rdata = RST_REG;
               end else begin
                  next_s.rresp = RESP_OKAY;
                  case (ri)
                     IDX_CON_MAIN: next_s.rdata = s.con_main;
                     IDX_CON_GAIN: next_s.rdata = s.con_gain;
                     IDX_CHAN: next_s.rdata = s.chan;
                     IDX_PINS: next_s.rdata = s.pins;
                     IDX_OVERRIDE: next_s.rdata = s.ovr;
                     default: next_s.rdata = s.trim;
                  endcase
               end
            end
         end
         ACR_R_DATA: begin
            if (s_axi_rready && s.rvalid) begin
               next_s.rvalid = 1'b0;
               next_s.rst = ACR_R_IDLE;
            end
         end
         default: begin
            next_s.rst = ACR_R_IDLE;
         end
      endcase
      next_s.arready = (next_s.rst == ACR_R_IDLE);
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= rst_s;
      end else if (aclken) begin
         s <= next_s;
      end
   end

   // bus outputs
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = {24'h00_0000, s.rdata};
   assign s_axi_rresp = s.rresp;

   // analog controls, registered copy of the decoder; trim straight from its register
   assign amp_enable = s.outq.power;                         // [RULE_01]
   assign charge_pump_on = s.outq.cp;                        // [RULE_02]
   assign unity_feedback = s.outq.unity;                     // [RULE_03]
   assign drive_low_rail = s.outq.drv_lo;                    // [RULE_04]
   assign drive_high_rail = s.outq.drv_hi;                   // [RULE_04]
   assign ladder_enable = s.outq.ladder;                     // [RULE_06]
   assign ladder_r1 = s.outq.r1;
   assign ladder_r2 = s.outq.r2;
   assign inverting_input_pin_sel = s.outq.inv_pin;
   assign inverting_to_vss = s.outq.inv_vss;
   assign inverting_pins_release = s.outq.inv_release;
   assign noninverting_channel_sel = s.outq.ni_chan;
   assign noninverting_input_pin_sel = s.outq.ni_pin;
   assign offset_trim = s.trim;
   assign adc_from_amp = s.outq.adc_amp;                     // [RULE_11]
   assign amp_output_pin_port_off = s.outq.pin_port_off;     // [RULE_12]
   assign amp_output_pin_drive = s.outq.pin_drive;

endmodule

// file: acr_regs_sva.sv
`timescale 1ns/100ps
module acr_chk
   import acr_pkg::*;
#(
   parameter logic [ADC_CH_W-1:0] AMP_PIN_CH_BASE = 6'h0
) (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // read data and system inputs
   input logic s_axi_rvalid,
   input logic [31:0] s_axi_rdata,
   input logic [7:0] factory_trim,
   input logic [ADC_CH_W-1:0] adc_positive_channel,
   // amplifier mode
   input logic amp_enable,
   input logic unity_feedback,
   input logic drive_low_rail,
   input logic drive_high_rail,
   // ladder
   input logic ladder_enable,
   input logic [4:0] ladder_r1,
   input logic [4:0] ladder_r2,
   // source selection
   input logic [3:0] inverting_input_pin_sel,
   input logic inverting_to_vss,
   input logic inverting_pins_release,
   input logic [5:0] noninverting_channel_sel,
   input logic [3:0] noninverting_input_pin_sel,
   // trim, converter path and pin
   input logic [7:0] offset_trim,
   input logic adc_from_amp,
   input logic amp_output_pin_port_off,
   input logic amp_output_pin_drive
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // factory value seen during reset is the trim afterwards
   property p_trim;
      $rose(aresetn) |-> offset_trim == $past(factory_trim);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not reloaded");

   // ladder split totals sixteen units while enabled, both parts zero otherwise
   property p_ladder_on;
      ladder_enable |-> ladder_r1 + ladder_r2 == 5'h10 && ladder_r1 != 5'h0;
   endproperty
   a_ladder_on: assert property (p_ladder_on) else $error("bad split");

   property p_ladder_off;
      !ladder_enable |-> ladder_r1 == 5'h0 && ladder_r2 == 5'h0;
   endproperty
   a_ladder_off: assert property (p_ladder_off) else $error("ladder on");

   // unity feedback frees the inverting pins
   property p_unity;
      inverting_pins_release == unity_feedback && (!unity_feedback
         || (inverting_input_pin_sel == 4'h0 && !inverting_to_vss));
   endproperty
   a_unity: assert property (p_unity) else $error("unity routing");

   // one rail at most, only while powered
   property p_rail;
      drive_low_rail || drive_high_rail |->
         amp_enable && !(drive_low_rail && drive_high_rail);
   endproperty
   a_rail: assert property (p_rail) else $error("rail drive");

   property p_neg_sel;
      $onehot0(inverting_input_pin_sel) && !(inverting_to_vss
         && inverting_input_pin_sel != 4'h0);
   endproperty
   a_neg_sel: assert property (p_neg_sel) else $error("neg select");

   property p_pos_sel;
      $onehot0(noninverting_channel_sel) && (noninverting_input_pin_sel == 4'h0
         || noninverting_channel_sel == 6'h04);
   endproperty
   a_pos_sel: assert property (p_pos_sel) else $error("pos select");

   // amp pin codes on the converter take the amplifier output
   property p_adc;
      $stable(adc_positive_channel) |=> adc_from_amp ==
         ($past(adc_positive_channel) - AMP_PIN_CH_BASE < 4);
   endproperty
   a_adc: assert property (p_adc) else $error("converter path");

   property p_pin;
      amp_output_pin_port_off == (amp_enable || adc_from_amp)
         && amp_output_pin_drive == amp_output_pin_port_off;
   endproperty
   a_pin: assert property (p_pin) else $error("output pin");

   property p_rdata;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rdata: assert property (p_rdata) else $error("upper read bits");

   c_rail: cover property (drive_high_rail);
   c_ladder: cover property (ladder_enable && ladder_r1 == 5'h1);
   c_adc: cover property (adc_from_amp && !amp_enable);
endmodule

bind acr_regs acr_chk #(.AMP_PIN_CH_BASE(AMP_PIN_CH_BASE)) chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rdata(s_axi_rdata), .factory_trim(factory_trim),
   .adc_positive_channel(adc_positive_channel), .amp_enable(amp_enable),
   .unity_feedback(unity_feedback), .drive_low_rail(drive_low_rail),
   .drive_high_rail(drive_high_rail), .ladder_enable(ladder_enable),
   .ladder_r1(ladder_r1), .ladder_r2(ladder_r2),
   .inverting_input_pin_sel(inverting_input_pin_sel),
   .inverting_to_vss(inverting_to_vss),
   .inverting_pins_release(inverting_pins_release),
   .noninverting_channel_sel(noninverting_channel_sel),
   .noninverting_input_pin_sel(noninverting_input_pin_sel),
   .offset_trim(offset_trim), .adc_from_amp(adc_from_amp),
   .amp_output_pin_port_off(amp_output_pin_port_off),
   .amp_output_pin_drive(amp_output_pin_drive)
);

// file: amplifier_control_registers_bench.sv
`timescale 1ns/100ps
module amplifier_control_registers_bench;
   import acr_pkg::*;
   localparam logic [4:0] R1_TAB [8] = '{5'hF, 5'hE, 5'hC, 5'h8,
      5'h6, 5'h4, 5'h2, 5'h1};
   logic aclk = 1'b0;
   logic aresetn, aclken, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, override_source;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, amp_enable, charge_pump_on, unity_feedback;
   logic drive_low_rail, drive_high_rail, ladder_enable, inverting_to_vss;
   logic inverting_pins_release, adc_from_amp, amp_output_pin_port_off;
   logic amp_output_pin_drive;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, inverting_input_pin_sel;
   logic [3:0] noninverting_input_pin_sel;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] factory_trim, offset_trim;
   logic [5:0] adc_positive_channel, noninverting_channel_sel;
   logic [4:0] ladder_r1, ladder_r2;
   logic [34:0] outs;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;

   acr_regs uut (.*);

   // all decoded outputs in one vector
   assign outs = {amp_enable, charge_pump_on, unity_feedback, drive_low_rail,
      drive_high_rail, ladder_enable, ladder_r1, ladder_r2,
      inverting_input_pin_sel, inverting_to_vss, inverting_pins_release,
      noninverting_channel_sel, noninverting_input_pin_sel, adc_from_amp,
      amp_output_pin_port_off, amp_output_pin_drive};

   always #2 aclk = ~aclk;

   // cut a hang short
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   // expected decode of the settings
   function automatic logic [34:0] exp_out(input logic [7:0] m, g, c, p, o,
         input logic os, input logic [5:0] ch);
      logic s, u, a;
      logic [2:0] cf;
      logic [4:0] r1;
      s = os ^ o[3];
      cf = s ? o[6:4] : o[2:0];
      u = o[7] ? cf == 3'h4 : m[3];
      a = ch < 6'h4;
      r1 = g[3] ? R1_TAB[g[6:4]] : 5'h0;
      return {m[7], m[5], u,
         m[7] & (o[7] ? !s && cf == 3'h7 : m[1:0] == 2'h1),
         m[7] & (o[7] ? s && cf == 3'h7 : m[1:0] == 2'h2),
         g[3], r1, g[3] ? 5'h10 - r1 : 5'h0,
         (!u && g[2:0] < 3'h4) ? 4'h1 << g[1:0] : 4'h0,
         !u && g[2:0] == 3'h7, u,
         c[2:0] < 3'h6 ? 6'h01 << c[2:0] : 6'h00,
         c[2:0] == 3'h2 ? 4'h1 << p[1:0] : 4'h0,
         a, m[7] | a, m[7] | a};
   endfunction

   // write: address and data offered together, wait for response
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= ($urandom() & 32'hFFFF_FF00) | 32'(d);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(64'(s_axi_bresp), 64'(er));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check(64'(s_axi_rdata), 64'(ed));
      check(64'(s_axi_rresp), 64'(er));
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   initial begin
      logic [7:0] v [5];
      logic [7:0] mk [5];
      logic [7:0] ft, nf;
      logic [34:0] e;
      mk = '{MASK_CON_MAIN, MASK_CON_GAIN, MASK_CHAN, MASK_PINS, MASK_FULL};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, override_source, s_axi_awaddr, s_axi_araddr,
         s_axi_awprot, s_axi_arprot, s_axi_wdata, adc_positive_channel} = '0;
      aclken = 1'b1;
      s_axi_wstrb = 4'h1;
      factory_trim = 8'h5A;
      void'($urandom(19029));
      // reset values of every register
      do_reset();
      for (int k = 0; k < 5; k++)
         rd(ad(8'(IDX_CON_MAIN + k)), 32'h0, RESP_OKAY);
      rd(ad(IDX_TRIM), 32'h5A, RESP_OKAY);
      $display("reset values test done");
      // settings in, decoded controls out, corners first
      for (int n = 0; n < 40; n++) begin
         foreach (v[k])
            v[k] = n < 2 ? {8{n == 0}} : 8'($urandom);
         if (n > 1 && v[4][0])
            v[4][7] = 1'b0;
         override_source <= 1'($urandom);
         adc_positive_channel <= n < 2 ? 6'(n + 3) : 6'($urandom);
         for (int k = 0; k < 5; k++)
            wr(ad(8'(IDX_CON_MAIN + k)), v[k], RESP_OKAY);
         for (int k = 0; k < 5; k++)
            rd(ad(8'(IDX_CON_MAIN + k)), 32'(v[k] & mk[k]), RESP_OKAY);
         repeat (2) @(posedge aclk);
         e = exp_out(v[0], v[1], v[2], v[3], v[4], override_source,
            adc_positive_channel);
         check(64'(outs[34:30]), 64'(e[34:30]));
         check(64'(outs[29:19]), 64'(e[29:19]));
         check(64'(outs[18:0]), 64'(e[18:0]));
         check(64'(outs[15:3]), 64'(e[15:3]));
         check(64'(outs[2:0]), 64'(e[2:0]));
      end
      $display("decode test done");
      // refused writes leave registers alone
      s_axi_wstrb <= 4'h0;
      wr(ad(IDX_TRIM), 8'h3C, RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd(ad(IDX_TRIM), 32'h5A, RESP_OKAY);
      wr(12'hA8C, 8'h80, RESP_DECERR);
      rd(12'hA8C, 32'h0, RESP_DECERR);
      wr(ad(8'hA9), 8'h80, RESP_DECERR);
      rd(ad(8'h00), 32'h0, RESP_DECERR);
      rd(ad(IDX_CON_MAIN), 32'(v[0] & MASK_CON_MAIN), RESP_OKAY);
      // written trim is lost on the next reset
      ft = 8'($urandom);
      nf = ~ft;
      wr(ad(IDX_TRIM), nf, RESP_OKAY);
      rd(ad(IDX_TRIM), 32'(nf), RESP_OKAY);
      check(64'(offset_trim), 64'(nf));
      factory_trim <= ft;
      do_reset();
      rd(ad(IDX_TRIM), 32'(ft), RESP_OKAY);
      check(64'(offset_trim), 64'(ft));
      rd(ad(IDX_CON_MAIN), 32'h0, RESP_OKAY);
      $display("trim and refusal test done");
      // calibration: unity, pin reference, amp output to converter
      override_source <= 1'b0;
      adc_positive_channel <= 6'h02;
      v = '{8'hA8, 8'h00, 8'h02, 8'h01, 8'h00};
      foreach (v[k])
         wr(ad(8'(IDX_CON_MAIN + k)), v[k], RESP_OKAY);
      wr(ad(IDX_TRIM), nf, RESP_OKAY);
      repeat (2) @(posedge aclk);
      e = exp_out(v[0], v[1], v[2], v[3], v[4], 1'b0, 6'h02);
      check(64'(outs), 64'(e));
      check(64'(offset_trim), 64'(nf));
      $display("calibration test done");
      complete_run();
   end
endmodule
